// file: tcc_defines.svh
// Register offsets, field positions, reset values and timing counts for the counter/compare unit
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TCC_OFS_FLAGS2      4'h0
`define TCC_OFS_ENABLES2    4'h1
`define TCC_OFS_PRIORITY2   4'h2
`define TCC_OFS_CNT_LOW     4'h3
`define TCC_OFS_CNT_HIGH    4'h4
`define TCC_OFS_T1CTRL      4'h5
`define TCC_OFS_CNTCTRL     4'h6
`define TCC_OFS_MODECTRL    4'h7
`define TCC_OFS_DATA_LOW    4'h8
`define TCC_OFS_DATA_HIGH   4'h9
`define TCC_OFS_BUSIO       4'hA
`define TCC_OFS_GLOBAL      4'hB
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TCC_BIT_OVF_FLAG    1
`define TCC_BIT_UNIT_FLAG   0
`define TCC_BIT_OSC_EN      3
`define TCC_BIT_WIDE        7
`define TCC_BIT_PS_HI       5
`define TCC_BIT_PS_LO       4
`define TCC_BIT_SYNC_DIS    2
`define TCC_BIT_CLK_SEL     1
`define TCC_BIT_RUN         0
`define TCC_BIT_TSTAMP      4
`define TCC_BIT_ADC_EN      0
// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define TCC_RST_BYTE        8'h00
`define TCC_RST_WORD        16'h0000
`define TCC_CNT_MAX         16'hFFFF
`define TCC_INSTR_DIV       2'h3
`define TCC_CAP_DIV4        4'h3
`define TCC_CAP_DIV16       4'hF
`endif

// file: tcc_pkg.sv
// Types shared by the counter/compare unit
package tcc_pkg;
  typedef enum logic [1:0] {TCC_OFF, TCC_CAPTURE, TCC_COMPARE, TCC_PWM} tcc_class_t;
endpackage

// file: tcc_edge_ps.sv
// Rising-edge detector and 1/2/4/8 input prescaler for the counter clock
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_edge_ps
  import tcc_pkg::*;
#(
  parameter int PS_W = 3
)(
  input  wire logic       sys_clk,    // System clock
  input  wire logic       srst,       // Synchronous reset
  input  wire logic       src,        // Selected clock source level
  input  wire logic       ext_mode,   // Source is external edge input
  input  wire logic       clr,        // Clear prescaler
  input  wire logic [1:0] ps_sel,     // Prescale code
  output logic            tick        // One-cycle count enable
);
  typedef struct packed {
    logic            prev;
    logic            armed;
    logic [PS_W-1:0] cnt;
  } tcc_eps_t;
  tcc_eps_t st, next_st;
  logic     edge_ok;
  logic [PS_W-1:0] lim;

  always_comb
  begin
    next_st = st;
    next_st.prev = src;
    lim = PS_W'((1 << ps_sel) - 1);
    // External source counts rising edges only after a first falling edge
    if (!ext_mode)
      next_st.armed = 1'b0;
    else if (st.prev && !src)
      next_st.armed = 1'b1;
    edge_ok = ext_mode ? (!st.prev && src && st.armed) : src;
    tick = 1'b0;
    if (clr)
      next_st.cnt = '0;
    else if (edge_ok)
    begin
      if (st.cnt >= lim)
      begin
        next_st.cnt = '0;
        tick = 1'b1;
      end
      else
        next_st.cnt = st.cnt + PS_W'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule // tcc_edge_ps
`default_nettype wire

// file: tcc_ctrl.sv
// 16-bit counter time base with capture/compare/PWM mode control
//
// What this block does
// - Secondary oscillator clocks counter when enabled, selected
// - Oscillator source advances counter on rising edges
// - 16-bit counter wraps FFFFh to 0000h
// - Wrap sets overflow flag bit 1
// - Overflow request gated by enable bit 1
// - Special event mode match clears counter
// - Special event requests conversion if converter enabled
// - Compare pair acts as counter period
// - Software counter write beats trigger clear
// - Trigger clear never sets overflow flag
// - PWM duty: control bits 5-4 plus data low
// - Mode 0000 disables and resets unit
// - Mode 0010 toggles pin, sets flag
// - Capture modes: fall (rise with timestamp select), rise, 4th, 16th rise
// - Timestamp select replaces pin with message events
// - Mode 1000 pin low, high on match
// - Mode 1001 pin high, low on match
// - Mode 1010 flag only, pin shows port
// - Mode 1011 trigger, clear, set flag
// - Data register is two readable writable bytes
// - Clock select: instruction clock or external edges
// - Prescale divides by 1, 2, 4, 8
// - Wide mode buffers high byte via low access
// - Only low-byte writes clear prescaler
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_ctrl
  import tcc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int DUTY_W = 10
)(
  input  wire logic              sys_clk,       // 10 MHz system clock
  input  wire logic              srst,          // Synchronous reset, active high
  input  wire logic [3:0]        addr,          // Register address
  input  wire logic [7:0]        wdata,         // Write data
  input  wire logic              wr,            // Write strobe
  input  wire logic              rd,            // Read strobe
  output logic      [7:0]        rdata,         // Read data, cycle after rd
  input  wire logic              ext_clk_in,    // External counter clock input
  input  wire logic              sec_osc_in,    // Secondary oscillator level
  input  wire logic              cap_pin,       // Capture input pin
  input  wire logic              msg_rx,        // Received-message pulse
  input  wire logic              port_level,    // Ordinary port output state
  output logic                   cmp_pin,       // Compare output pin level
  output logic                   adc_start,     // Conversion start pulse
  output logic                   ovf_irq,       // Overflow interrupt request
  output logic [DUTY_W-1:0]      pwm_duty       // 10-bit PWM duty value
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       flags2;
    logic [7:0]       enables2;
    logic [7:0]       priority2;
    logic [7:0]       t1ctrl;
    logic [7:0]       cntctrl;
    logic [5:0]       modectrl;
    logic [7:0]       busio;
    logic [7:0]       global_ctl;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       hi_buf;
    logic [CNT_W-1:0] data;
    logic             pin;
    logic             cap_prev;
    logic [3:0]       cap_cnt;
    logic [7:0]       rdata;
    logic             adc;
    logic [DUTY_W-1:0] duty;
  } tcc_st_t;
  tcc_st_t st, next_st;

  logic       tick;
  logic       ext_sel;
  logic       clk_src;
  logic       cnt_wr;
  logic       cnt_lo_wr;
  logic       match;
  logic       cap_ev;
  logic       cap_src;
  logic [3:0] mode;
  logic [7:0] hw_set;
  logic [CNT_W-1:0] cnt_inc;

  function automatic tcc_class_t mode_class(input logic [3:0] m);
    if (m[3:2] == 2'b11)
      return TCC_PWM;
    else if (m[3:2] == 2'b01)
      return TCC_CAPTURE;
    else if (m[3] || m == 4'h2)
      return TCC_COMPARE;
    else
      return TCC_OFF; // 0000 and reserved 0001/0011
  endfunction

  function automatic logic is_wr(input logic [3:0] a, input logic [3:0] ofs);
    return wr && (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Counter clock source and prescaler
  // ---------------------------------------------------------------
  assign mode      = st.modectrl[3:0];
  assign ext_sel   = st.cntctrl[`TCC_BIT_CLK_SEL];
  assign cnt_lo_wr = is_wr(addr, `TCC_OFS_CNT_LOW);
  assign cnt_wr    = cnt_lo_wr || (is_wr(addr, `TCC_OFS_CNT_HIGH) && !st.cntctrl[`TCC_BIT_WIDE]);
  // Oscillator feeds counter only with both enable and select set
  assign clk_src   = !ext_sel ? 1'b1 :
                     (st.t1ctrl[`TCC_BIT_OSC_EN] ? sec_osc_in : ext_clk_in);

  tcc_edge_ps #(.PS_W(3)) u_ps (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .src      (clk_src),
    .ext_mode (ext_sel),
    .clr      (cnt_lo_wr),
    .ps_sel   (st.cntctrl[`TCC_BIT_PS_HI:`TCC_BIT_PS_LO]),
    .tick     (tick)
  );

  assign match   = (mode_class(mode) == TCC_COMPARE) && (st.cnt == st.data);
  assign cap_src = st.busio[`TCC_BIT_TSTAMP] ? msg_rx : cap_pin;
  assign cnt_inc = st.cnt + CNT_W'(1);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.adc = 1'b0;
    next_st.rdata = 8'h00;
    next_st.cap_prev = cap_src;
    cap_ev = 1'b0;
    hw_set = 8'h00;

    // Counter advance and wrap
    if (st.cntctrl[`TCC_BIT_RUN] && tick)
    begin
      next_st.cnt = cnt_inc;
      if (st.cnt == `TCC_CNT_MAX)
        hw_set[`TCC_BIT_OVF_FLAG] = 1'b1;
    end

    // Compare actions
    if (match)
    begin
      case (mode)
        4'h2: next_st.pin = ~st.pin;
        4'h8: next_st.pin = 1'b1;
        4'h9: next_st.pin = 1'b0;
        4'hB:
        begin
          // Trigger clear, period restart, no overflow flag
          next_st.cnt = `TCC_RST_WORD;
          next_st.adc = st.global_ctl[`TCC_BIT_ADC_EN];
        end
        default: next_st.pin = st.pin;
      endcase
      hw_set[`TCC_BIT_UNIT_FLAG] = 1'b1;
    end

    // Capture events with event prescale
    if (mode_class(mode) == TCC_CAPTURE)
    begin
      if (mode == 4'h4)
        cap_ev = st.busio[`TCC_BIT_TSTAMP] ? (cap_src && !st.cap_prev) : (st.cap_prev && !cap_src);
      else if (!st.cap_prev && cap_src)
      begin
        if (mode == 4'h5)
          cap_ev = 1'b1;
        else
        begin
          next_st.cap_cnt = st.cap_cnt + 4'h1;
          cap_ev = (mode == 4'h6) ? (st.cap_cnt[1:0] == `TCC_CAP_DIV4) :
                                    (st.cap_cnt == `TCC_CAP_DIV16);
          if (mode == 4'h6 && cap_ev)
            next_st.cap_cnt = 4'h0;
        end
      end
      if (cap_ev)
      begin
        next_st.data = st.cnt;
        hw_set[`TCC_BIT_UNIT_FLAG] = 1'b1;
      end
    end
    else
      next_st.cap_cnt = 4'h0;

    next_st.flags2 = st.flags2 | hw_set;

    // PWM duty value
    if (mode_class(mode) == TCC_PWM)
      next_st.duty = {st.data[7:0], st.modectrl[5:4]};

    // Register writes; counter write wins over trigger clear
    if (wr)
    begin
      if (addr == `TCC_OFS_FLAGS2)
        // Software clears, hardware set in same cycle wins
        next_st.flags2 = wdata | hw_set;
      else if (addr == `TCC_OFS_ENABLES2)
        next_st.enables2 = wdata;
      else if (addr == `TCC_OFS_PRIORITY2)
        next_st.priority2 = wdata;
      else if (addr == `TCC_OFS_CNT_LOW)
        next_st.cnt = st.cntctrl[`TCC_BIT_WIDE] ? {st.hi_buf, wdata} : {st.cnt[15:8], wdata};
      else if (addr == `TCC_OFS_CNT_HIGH)
      begin
        if (st.cntctrl[`TCC_BIT_WIDE])
          next_st.hi_buf = wdata;
        else
          next_st.cnt = {wdata, st.cnt[7:0]};
      end
      else if (addr == `TCC_OFS_T1CTRL)
        next_st.t1ctrl = wdata;
      else if (addr == `TCC_OFS_CNTCTRL)
        next_st.cntctrl = wdata;
      else if (addr == `TCC_OFS_MODECTRL)
      begin
        next_st.modectrl = wdata[5:0];
        if (wdata[3:0] == 4'h0)
        begin
          // Disable resets unit state
          next_st.pin = 1'b0;
          next_st.cap_cnt = 4'h0;
          next_st.duty = '0;
        end
        else if (wdata[3:0] == 4'h8)
          next_st.pin = 1'b0;
        else if (wdata[3:0] == 4'h9)
          next_st.pin = 1'b1;
      end
      else if (addr == `TCC_OFS_DATA_LOW)
        next_st.data = {st.data[15:8], wdata};
      else if (addr == `TCC_OFS_DATA_HIGH)
        next_st.data = {wdata, st.data[7:0]};
      else if (addr == `TCC_OFS_BUSIO)
        next_st.busio = wdata;
      else if (addr == `TCC_OFS_GLOBAL)
        next_st.global_ctl = wdata;
    end

    // Register reads
    if (rd)
    begin
      if (addr == `TCC_OFS_FLAGS2)
        next_st.rdata = st.flags2;
      else if (addr == `TCC_OFS_ENABLES2)
        next_st.rdata = st.enables2;
      else if (addr == `TCC_OFS_PRIORITY2)
        next_st.rdata = st.priority2;
      else if (addr == `TCC_OFS_CNT_LOW)
      begin
        next_st.rdata = st.cnt[7:0];
        if (st.cntctrl[`TCC_BIT_WIDE])
          next_st.hi_buf = st.cnt[15:8];
      end
      else if (addr == `TCC_OFS_CNT_HIGH)
        next_st.rdata = st.cntctrl[`TCC_BIT_WIDE] ? st.hi_buf : st.cnt[15:8];
      else if (addr == `TCC_OFS_T1CTRL)
        next_st.rdata = st.t1ctrl;
      else if (addr == `TCC_OFS_CNTCTRL)
        next_st.rdata = st.cntctrl;
      else if (addr == `TCC_OFS_MODECTRL)
        next_st.rdata = {2'b00, st.modectrl};
      else if (addr == `TCC_OFS_DATA_LOW)
        next_st.rdata = st.data[7:0];
      else if (addr == `TCC_OFS_DATA_HIGH)
        next_st.rdata = st.data[15:8];
      else if (addr == `TCC_OFS_BUSIO)
        next_st.rdata = st.busio;
      else if (addr == `TCC_OFS_GLOBAL)
        next_st.rdata = st.global_ctl;
      else
        next_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata     = st.rdata;
  assign adc_start = st.adc;
  assign pwm_duty  = st.duty;
  assign ovf_irq   = st.flags2[`TCC_BIT_OVF_FLAG] && st.enables2[`TCC_BIT_OVF_FLAG];
  assign cmp_pin   = (mode == 4'hA) ? port_level : st.pin;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_wrap_flag: assert property (@(posedge sys_clk) disable iff (srst)
    (st.cntctrl[0] && tick && st.cnt == 16'hFFFF && !cnt_wr && !(wr && addr == 4'h0))
      |=> (st.cnt == 16'h0000 && st.flags2[1]))
    else $error("wrap did not set overflow flag");
  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (srst)
    (st.cntctrl[0] && tick && st.cnt == 16'hFFFF && st.enables2[1] && !cnt_wr
      && !(wr && (addr == 4'h0 || addr == 4'h1))) |=> ovf_irq)
    else $error("overflow request not raised");
  chk_trig_clear: assert property (@(posedge sys_clk) disable iff (srst)
    (match && mode == 4'hB && !cnt_wr) |=> (st.cnt == 16'h0000))
    else $error("trigger did not clear counter");
  chk_adc_req: assert property (@(posedge sys_clk) disable iff (srst)
    (match && mode == 4'hB) |=> (adc_start == $past(st.global_ctl[0])))
    else $error("conversion request wrong");
  chk_write_wins: assert property (@(posedge sys_clk) disable iff (srst)
    (match && mode == 4'hB && wr && addr == 4'h3 && !st.cntctrl[7])
      |=> (st.cnt[7:0] == $past(wdata)))
    else $error("counter write lost to trigger");
  chk_trig_no_ovf: assert property (@(posedge sys_clk) disable iff (srst)
    (match && mode == 4'hB && !st.flags2[1] && !(wr && addr == 4'h0)
      && !(tick && st.cnt == 16'hFFFF)) |=> !st.flags2[1])
    else $error("trigger set overflow flag");
  chk_toggle: assert property (@(posedge sys_clk) disable iff (srst)
    (match && mode == 4'h2 && !wr) |=> (st.pin != $past(st.pin) && st.flags2[0]))
    else $error("toggle mode did not toggle");
  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (srst)
    (st.flags2[0] && !(wr && addr == 4'h0)) |=> st.flags2[0])
    else $error("unit flag dropped by hardware");
  chk_reserved: assert property (@(posedge sys_clk) disable iff (srst)
    ((mode == 4'h1 || mode == 4'h3) && !st.flags2[0] && !wr) |=> !st.flags2[0])
    else $error("reserved mode raised a flag");
  chk_disable_reset: assert property (@(posedge sys_clk) disable iff (srst)
    (wr && addr == 4'h7 && wdata[3:0] == 4'h0) |=> (cmp_pin == 1'b0 && pwm_duty == '0))
    else $error("disable did not reset unit");
  chk_capture_load: assert property (@(posedge sys_clk) disable iff (srst)
    (cap_ev && !(wr && (addr == 4'h0 || addr == 4'h8 || addr == 4'h9)))
      |=> (st.data == $past(st.cnt) && st.flags2[0]))
    else $error("capture did not load data");
endmodule // tcc_ctrl
`default_nettype wire

// file: tcc_far_end.sv
// Far-side model: capture and message sources, port state, clock sources, conversion consumer
`timescale 1ns/100ps
`default_nettype none
module tcc_far_end
  import tcc_pkg::*;
(
  input  wire logic sys_clk,     // System clock
  input  wire logic adc_start,   // Conversion start pulse
  output var  logic cap_pin,     // Capture input pin
  output var  logic msg_rx,      // Received-message event
  output var  logic port_level,  // Ordinary port state
  output var  logic ext_clk_in,  // External counter clock
  output var  logic sec_osc_in   // Secondary oscillator level
);
  int adc_count = 0;

  initial
  begin
    {cap_pin, msg_rx, port_level, ext_clk_in, sec_osc_in} = 5'h00;
  end

  // Conversion consumer counts start pulses
  always @(posedge sys_clk)
    if (adc_start === 1'b1)
      adc_count <= adc_count + 1;

  task automatic drive(input int src, input logic v);
    case (src)
      0:       cap_pin <= v;
      1:       msg_rx <= v;
      2:       ext_clk_in <= v;
      default: sec_osc_in <= v;
    endcase
  endtask

  // Two cycles high, two low, so the synchronous inputs see every level
  task automatic pulse(input int src, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      drive(src, 1'b1);
      repeat (2) @(posedge sys_clk);
      drive(src, 1'b0);
      @(posedge sys_clk);
    end
  endtask

  task automatic set_port(input logic v);
    @(posedge sys_clk);
    port_level <= v;
  endtask
endmodule // tcc_far_end
`default_nettype wire

// file: testbench.sv
// Self-checking testbench for the counter/compare unit
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defines.svh"
module testbench
  import tcc_pkg::*;
;
  logic        sys_clk, srst, wr, rd;
  logic [3:0]  addr, cm;
  logic [7:0]  wdata, rdata, rv;
  logic        cap_pin, msg_rx, port_level, ext_clk_in, sec_osc_in;
  logic        cmp_pin, adc_start, ovf_irq;
  logic [9:0]  pwm_duty;
  logic [15:0] v;
  int          err_total, checks, i, j, kk, c0;

  tcc_ctrl dut (.sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ext_clk_in(ext_clk_in), .sec_osc_in(sec_osc_in),
    .cap_pin(cap_pin), .msg_rx(msg_rx), .port_level(port_level), .cmp_pin(cmp_pin),
    .adc_start(adc_start), .ovf_irq(ovf_irq), .pwm_duty(pwm_duty));

  tcc_far_end far (.sys_clk(sys_clk), .adc_start(adc_start), .cap_pin(cap_pin),
    .msg_rx(msg_rx), .port_level(port_level), .ext_clk_in(ext_clk_in),
    .sec_osc_in(sec_osc_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(what, {8'h00, exp}, {8'h00, rv});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic load_cnt(input logic [15:0] x);
    bus(1'b1, `TCC_OFS_CNTCTRL, 8'h00);
    bus(1'b1, `TCC_OFS_CNT_HIGH, x[15:8]);
    bus(1'b1, `TCC_OFS_CNT_LOW, x[7:0]);
  endtask

  task automatic rd_cnt(output logic [15:0] x);
    bus(1'b0, `TCC_OFS_CNT_LOW, 8'h00);
    x[7:0] = rv;
    bus(1'b0, `TCC_OFS_CNT_HIGH, 8'h00);
    x[15:8] = rv;
  endtask

  // Prime the edge detector, clear count and prescaler, then count n source pulses
  task automatic src_run(input int src, input logic [1:0] ps, input int n,
                         output logic [15:0] x);
    bus(1'b1, `TCC_OFS_T1CTRL, (src == 3) ? 8'h08 : 8'h00);
    bus(1'b1, `TCC_OFS_CNTCTRL, {2'b00, ps, 4'b0011});
    far.pulse(src, 1);
    bus(1'b1, `TCC_OFS_CNT_HIGH, 8'h00);
    bus(1'b1, `TCC_OFS_CNT_LOW, 8'h00);
    far.pulse(src, n);
    rd_cnt(x);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #3000000;
    err_total++;
    report_and_stop;
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    bus(1'b1, 4'hC, 8'hFF);
    for (i = 0; i < 13; i++)
      rd_chk("reset value", i[3:0], 8'h00);
    bus(1'b1, `TCC_OFS_DATA_LOW, 8'h5A);
    bus(1'b1, `TCC_OFS_DATA_HIGH, 8'hC3);
    rd_chk("data low", `TCC_OFS_DATA_LOW, 8'h5A);
    rd_chk("data high", `TCC_OFS_DATA_HIGH, 8'hC3);
    // Wrap and overflow flag
    load_cnt(16'hFFF0);
    bus(1'b1, `TCC_OFS_CNTCTRL, 8'h01);
    idle(40);
    bus(1'b1, `TCC_OFS_CNTCTRL, 8'h00);
    rd_cnt(v);
    check("wrapped count", 16'h0001, {15'h0, v < 16'h0040});
    rd_chk("overflow flag", `TCC_OFS_FLAGS2, 8'h02);
    check("irq masked", 16'h0000, {15'h0, ovf_irq});
    bus(1'b1, `TCC_OFS_ENABLES2, 8'h02);
    check("irq enabled", 16'h0001, {15'h0, ovf_irq});
    idle(30);
    rd_chk("flag held", `TCC_OFS_FLAGS2, 8'h02);
    bus(1'b1, `TCC_OFS_FLAGS2, 8'h00);
    check("irq cleared", 16'h0000, {15'h0, ovf_irq});
    bus(1'b1, `TCC_OFS_ENABLES2, 8'h00);
    // Wide access through the high-byte buffer
    bus(1'b1, `TCC_OFS_CNTCTRL, 8'h80);
    bus(1'b1, `TCC_OFS_CNT_HIGH, 8'h56);
    bus(1'b1, `TCC_OFS_CNT_LOW, 8'h78);
    bus(1'b1, `TCC_OFS_CNT_HIGH, 8'h11);
    rd_chk("wide low", `TCC_OFS_CNT_LOW, 8'h78);
    rd_chk("wide high", `TCC_OFS_CNT_HIGH, 8'h56);
    // External source and prescaler
    for (i = 0; i < 4; i++)
    begin
      src_run(2, i[1:0], 8, v);
      check("prescaled count", 16'(8 >> i), v);
    end
    src_run(2, 2'h3, 4, v);
    bus(1'b1, `TCC_OFS_CNT_HIGH, 8'h00);
    far.pulse(2, 4);
    rd_cnt(v);
    check("high write keeps prescaler", 16'h0001, v);
    src_run(3, 2'h0, 5, v);
    check("oscillator count", 16'h0005, v);
    // Compare modes: set-high, set-low, toggle
    for (i = 0; i < 3; i++)
    begin
      cm = (i == 0) ? 4'h8 : (i == 1) ? 4'h9 : 4'h2;
      bus(1'b1, `TCC_OFS_MODECTRL, 8'h00);
      load_cnt(16'h0000);
      bus(1'b1, `TCC_OFS_DATA_HIGH, 8'h00);
      bus(1'b1, `TCC_OFS_DATA_LOW, 8'h08);
      bus(1'b1, `TCC_OFS_FLAGS2, 8'h00);
      bus(1'b1, `TCC_OFS_MODECTRL, {4'h0, cm});
      idle(2);
      check("pin on entry", {15'h0, i == 1}, {15'h0, cmp_pin});
      bus(1'b1, `TCC_OFS_CNTCTRL, 8'h01);
      idle(20);
      check("pin after match", {15'h0, i != 1}, {15'h0, cmp_pin});
      rd_chk("unit flag", `TCC_OFS_FLAGS2, 8'h01);
    end
    bus(1'b1, `TCC_OFS_MODECTRL, 8'h00);
    idle(2);
    check("pin after disable", 16'h0000, {15'h0, cmp_pin});
    load_cnt(16'h0000);
    bus(1'b1, `TCC_OFS_FLAGS2, 8'h00);
    bus(1'b1, `TCC_OFS_MODECTRL, 8'h0A);
    bus(1'b1, `TCC_OFS_CNTCTRL, 8'h01);
    idle(20);
    for (i = 1; i >= 0; i--)
    begin
      far.set_port(i[0]);
      idle(1);
      check("pin shows port", {15'h0, i[0]}, {15'h0, cmp_pin});
    end
    rd_chk("software event flag", `TCC_OFS_FLAGS2, 8'h01);
    // Special event: period, conversion request, no overflow flag
    bus(1'b1, `TCC_OFS_MODECTRL, 8'h00);
    load_cnt(16'h0000);
    bus(1'b1, `TCC_OFS_FLAGS2, 8'h00);
    bus(1'b1, `TCC_OFS_DATA_LOW, 8'h10);
    bus(1'b1, `TCC_OFS_GLOBAL, 8'h01);
    bus(1'b1, `TCC_OFS_MODECTRL, 8'h0B);
    for (j = 1; j >= 0; j--)
    begin
      c0 = far.adc_count;
      bus(1'b1, `TCC_OFS_CNTCTRL, 8'h01);  // timer mode for trigger clearing
      idle(100);
      bus(1'b1, `TCC_OFS_CNTCTRL, 8'h00);
      rd_cnt(v);
      check("period bound", 16'h0001, {15'h0, v <= 16'h0010});
      check("conversion requests", {15'h0, j == 1},
            {15'h0, far.adc_count - c0 >= 4});
      check("conversion count", 16'h0000, {15'h0, j == 0 && far.adc_count != c0});
      rd_chk("no overflow flag", `TCC_OFS_FLAGS2, 8'h01);
      bus(1'b1, `TCC_OFS_GLOBAL, 8'h00);
    end
    // Capture from pin, then from received messages
    for (j = 0; j < 2; j++)
    begin
      bus(1'b1, `TCC_OFS_BUSIO, j ? 8'h10 : 8'h00);
      for (i = 0; i < 4; i++)
      begin
        kk = (i < 2) ? 1 : (i == 2) ? 4 : 16;
        bus(1'b1, `TCC_OFS_MODECTRL, 8'h00);
        load_cnt(16'h1230 + 16'(i));
        bus(1'b1, `TCC_OFS_DATA_LOW, 8'h00);
        bus(1'b1, `TCC_OFS_DATA_HIGH, 8'h00);
        bus(1'b1, `TCC_OFS_FLAGS2, 8'h00);
        bus(1'b1, `TCC_OFS_MODECTRL, 8'h04 + 8'(i));
        far.pulse(1 - j, 16);
        far.pulse(j, kk - 1);
        rd_chk("no early capture", `TCC_OFS_FLAGS2, 8'h00);
        far.pulse(j, 1);
        rd_chk("capture flag", `TCC_OFS_FLAGS2, 8'h01);
        rd_chk("captured low", `TCC_OFS_DATA_LOW, 8'h30 + 8'(i));
        rd_chk("captured high", `TCC_OFS_DATA_HIGH, 8'h12);
      end
    end
    bus(1'b1, `TCC_OFS_BUSIO, 8'h00);
    // Reserved modes
    for (i = 1; i < 4; i += 2)
    begin
      bus(1'b1, `TCC_OFS_MODECTRL, 8'h00);
      load_cnt(16'h0000);
      bus(1'b1, `TCC_OFS_DATA_HIGH, 8'h00);
      bus(1'b1, `TCC_OFS_DATA_LOW, 8'h04);
      bus(1'b1, `TCC_OFS_FLAGS2, 8'h00);
      bus(1'b1, `TCC_OFS_MODECTRL, 8'(i));
      bus(1'b1, `TCC_OFS_CNTCTRL, 8'h01);
      far.pulse(0, 2);
      bus(1'b1, `TCC_OFS_CNTCTRL, 8'h00);
      rd_chk("reserved flag", `TCC_OFS_FLAGS2, 8'h00);
      check("reserved pin", 16'h0000, {15'h0, cmp_pin});
    end
    // PWM duty over all four PWM codes
    bus(1'b1, `TCC_OFS_DATA_LOW, 8'hA5);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, `TCC_OFS_MODECTRL, {2'b00, i[1:0], 2'b11, i[1:0]});
      idle(2);
      check("duty", {6'h00, 8'hA5, i[1:0]}, {6'h00, pwm_duty});
    end
    bus(1'b1, `TCC_OFS_MODECTRL, 8'h00);
    idle(2);
    check("duty after disable", 16'h0000, {6'h00, pwm_duty});
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
